/* File: fdcr_map.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef FDCR_MAP_SVH
`define FDCR_MAP_SVH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define FDCR_DMC_IDX       10'h3f2
`define FDCR_TAPE_IDX      10'h3f3
`define FDCR_RATE_IDX      10'h3f4
`define FDCR_DMC_ADDR      {`FDCR_DMC_IDX, 2'b00}
`define FDCR_TAPE_ADDR     {`FDCR_TAPE_IDX, 2'b00}
`define FDCR_RATE_ADDR     {`FDCR_RATE_IDX, 2'b00}

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FDCR_DMC_SEL0      0
`define FDCR_DMC_SEL1      1
`define FDCR_DMC_RUN       2
`define FDCR_DMC_GATE      3
`define FDCR_DMC_MOT0      4
`define FDCR_DMC_MOT1      5
`define FDCR_RATE_SRST     7
`define FDCR_RATE_PDOWN    6
`define FDCR_RATE_PC_LO    2
`define FDCR_RATE_PC_HI    4

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define FDCR_DMC_RST       8'h00
`define FDCR_TAPE_RST      2'h0
`define FDCR_RATE_RST      8'h02
`define FDCR_RATE_1M       2'h3
`define FDCR_PC_DEFAULT    3'h0
`define FDCR_PC_DEF_1M     3'h1
`define FDCR_PC_DEF_LOW    3'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define FDCR_CLK_NS        50
`define FDCR_SRST_MIN_NS   100
`define FDCR_SRST_CYC      ((`FDCR_SRST_MIN_NS + `FDCR_CLK_NS - 1) / `FDCR_CLK_NS)

`endif

/* File: fdcr_pkg.sv */
// Types shared by the floppy drive control register block
package fdcr_pkg;
    typedef logic [7:0] fdcr_byte_t;
    typedef logic [1:0] fdcr_rate_t;
    typedef enum logic {
        fdcr_mode_legacy,
        fdcr_mode_extended
    } fdcr_mode_t;
endpackage

/* File: fdcr_sync2.sv */
// Two flip-flop synchroniser for static configuration pins
`timescale 1ns/1ps
module fdcr_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         reset_n,
    // Data
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            meta_ff <= '0;
            dout    <= '0;
        end else begin
            meta_ff <= din;
            dout    <= meta_ff;
        end
    end
endmodule

/* File: fdcr_hold.sv */
// Minimum-length stretcher for a reset request pulse
`timescale 1ns/1ps
module fdcr_hold #(
    parameter int CYC = 2
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic reset_n,
    // Control
    input  wire logic trig,
    output logic      busy
);
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;

    assign nxt_cnt = trig ? 4'(CYC) : ((cnt_ff != 4'h0) ? cnt_ff - 4'h1 : 4'h0);
    assign busy    = (cnt_ff != 4'h0);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_ff <= 4'h0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
endmodule

/* File: fdcr_top.sv */
// Floppy drive control register bank with APB slave
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`include "fdcr_map.svh"
module fdcr_top (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Static configuration pins
    input  wire logic        mode_extended,
    input  wire logic        enhanced_mode2,
    input  wire logic        drive_swap,
    input  wire logic [7:0]  drive_type_config,
    input  wire logic [1:0]  boot_drive,
    // Neighbouring controller logic
    input  wire logic        ccr_rate_wr,
    input  wire logic [1:0]  ccr_rate,
    input  wire logic        data_status_access,
    // Drive pins
    output logic             unit_pick_0_n,
    output logic             unit_pick_1_n,
    output logic             spindle_out_0_n,
    output logic             spindle_out_1_n,
    // Controller side
    output logic             controller_reset,
    output logic             dma_irq_gate,
    output logic             low_power,
    output logic [1:0]       active_rate,
    output logic [2:0]       write_shift_sel,
    output logic [1:0]       tape_drive
);

    // ----------------------------------------
    // Configuration synchronisers
    // ----------------------------------------
    logic [12:0] cfg_sync;
    fdcr_pkg::fdcr_mode_t mode;
    logic       enh2;
    logic       swap;
    logic [7:0] type_cfg;
    logic [1:0] boot_sel;

    // Slow pins, so two flops each before use
    fdcr_sync2 #(
        .W (13)
    ) u_cfg_sync (
        .mclk    (mclk),
        .reset_n (reset_n),
        .din     ({mode_extended, enhanced_mode2, drive_swap,
                   drive_type_config, boot_drive}),
        .dout    (cfg_sync)
    );

    assign mode     = fdcr_pkg::fdcr_mode_t'(cfg_sync[12]);
    assign enh2     = cfg_sync[11];
    assign swap     = cfg_sync[10];
    assign type_cfg = cfg_sync[9:2];
    assign boot_sel = cfg_sync[1:0];

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    fdcr_pkg::fdcr_byte_t dmc_ff;
    fdcr_pkg::fdcr_byte_t nxt_dmc;
    logic [1:0]           tape_ff;
    logic [1:0]           nxt_tape;
    logic [2:0]           pc_ff;
    logic [2:0]           nxt_pc;
    fdcr_pkg::fdcr_rate_t rate_ff;
    fdcr_pkg::fdcr_rate_t nxt_rate;
    logic                 lowp_ff;
    logic                 nxt_lowp;

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    logic       setup_ph;
    logic       access_ok;
    logic       wr_go;
    logic       hit_dmc;
    logic       hit_tape;
    logic       hit_rate;
    logic       hit_any;
    logic [7:0] wbyte;

    assign setup_ph  = psel & ~penable;
    assign access_ok = psel & penable & pready;
    assign wr_go     = access_ok & pwrite;
    assign hit_dmc   = (paddr == `FDCR_DMC_ADDR);
    assign hit_tape  = (paddr == `FDCR_TAPE_ADDR);
    assign hit_rate  = (paddr == `FDCR_RATE_ADDR);
    assign hit_any   = hit_dmc | hit_tape | hit_rate;
    assign wbyte     = pwdata[7:0];

    logic wr_dmc;
    logic wr_tape;
    logic wr_rate;

    // Drive/motor register takes writes at any moment
    assign wr_dmc  = wr_go & hit_dmc;
    assign wr_tape = wr_go & hit_tape;
    assign wr_rate = wr_go & hit_rate;

    // ----------------------------------------
    // Software reset
    // ----------------------------------------
    logic run_now;
    logic run_fall;
    logic dsr_kick;
    logic hold_busy;
    logic sw_reset;

    // Held reset follows the stored run bit
    assign run_now  = dmc_ff[`FDCR_DMC_RUN];
    assign run_fall = wr_dmc & ~wbyte[`FDCR_DMC_RUN];
    // Rate bit 7 is a pulse only, never stored
    assign dsr_kick = wr_rate & wbyte[`FDCR_RATE_SRST];

    // A clear-then-set pair still yields the minimum width
    fdcr_hold #(
        .CYC (`FDCR_SRST_CYC)
    ) u_hold (
        .mclk    (mclk),
        .reset_n (reset_n),
        .trig    (run_fall | dsr_kick),
        .busy    (hold_busy)
    );

    assign sw_reset = ~run_now | hold_busy | dsr_kick | run_fall;

    // ----------------------------------------
    // Next register values
    // ----------------------------------------
    // Software reset touches none of these
    assign nxt_dmc  = wr_dmc ? wbyte : dmc_ff;
    assign nxt_tape = wr_tape ? wbyte[1:0] : tape_ff;
    assign nxt_pc   = wr_rate ? wbyte[`FDCR_RATE_PC_HI:`FDCR_RATE_PC_LO] : pc_ff;

    // Latest writer wins; a same-cycle clash goes to the rate register
    assign nxt_rate = wr_rate ? fdcr_pkg::fdcr_rate_t'(wbyte[1:0]) :
                      ccr_rate_wr ? ccr_rate : rate_ff;

    logic lowp_set;
    logic lowp_clr;

    // Entering low power beats a clear in the same cycle
    assign lowp_set = wr_rate & wbyte[`FDCR_RATE_PDOWN];
    assign lowp_clr = sw_reset | data_status_access;
    assign nxt_lowp = lowp_set | (lowp_ff & ~lowp_clr);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dmc_ff  <= `FDCR_DMC_RST;
            tape_ff <= `FDCR_TAPE_RST;
            pc_ff   <= 3'(`FDCR_RATE_RST >> `FDCR_RATE_PC_LO);
            rate_ff <= 2'(`FDCR_RATE_RST);
            lowp_ff <= 1'b0;
        end else begin
            dmc_ff  <= nxt_dmc;
            tape_ff <= nxt_tape;
            pc_ff   <= nxt_pc;
            rate_ff <= nxt_rate;
            lowp_ff <= nxt_lowp;
        end
    end

    // ----------------------------------------
    // Drive select and motor decode
    // ----------------------------------------
    logic [1:0] pick;
    logic       mot0;
    logic       mot1;
    logic       want0;
    logic       want1;
    logic       nxt_ds0_n;
    logic       nxt_ds1_n;
    logic       nxt_mt0_n;
    logic       nxt_mt1_n;

    // Binary code, so only one select can ever match
    assign pick  = {dmc_ff[`FDCR_DMC_SEL1], dmc_ff[`FDCR_DMC_SEL0]};
    // Bits 6 and 7 have no pin behind them
    assign mot0  = dmc_ff[`FDCR_DMC_MOT0];
    assign mot1  = dmc_ff[`FDCR_DMC_MOT1];
    // Codes 10 and 11 leave both selects idle
    assign want0 = (pick == 2'h0) & mot0;
    assign want1 = (pick == 2'h1) & mot1;

    // Swap exchanges the physical pins, not the register
    assign nxt_ds0_n = swap ? ~want1 : ~want0;
    assign nxt_ds1_n = swap ? ~want0 : ~want1;
    assign nxt_mt0_n = swap ? ~mot1 : ~mot0;
    assign nxt_mt1_n = swap ? ~mot0 : ~mot1;

    // ----------------------------------------
    // Controller controls
    // ----------------------------------------
    logic       nxt_gate;
    logic [2:0] nxt_shift;

    // Extended mode ignores the stored gate bit
    assign nxt_gate = (mode == fdcr_pkg::fdcr_mode_extended) ? 1'b1 : dmc_ff[`FDCR_DMC_GATE];

    // Default delay depends on rate: 1M is shorter than the low rates
    assign nxt_shift = (pc_ff != `FDCR_PC_DEFAULT) ? pc_ff :
                       (rate_ff == `FDCR_RATE_1M) ? `FDCR_PC_DEF_1M : `FDCR_PC_DEF_LOW;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            unit_pick_0_n   <= 1'b1;
            unit_pick_1_n   <= 1'b1;
            spindle_out_0_n <= 1'b1;
            spindle_out_1_n <= 1'b1;
            controller_reset <= 1'b1;
            dma_irq_gate    <= 1'b0;
            low_power       <= 1'b0;
            active_rate     <= 2'(`FDCR_RATE_RST);
            write_shift_sel <= `FDCR_PC_DEF_LOW;
            tape_drive      <= `FDCR_TAPE_RST;
        end else begin
            unit_pick_0_n   <= nxt_ds0_n;
            unit_pick_1_n   <= nxt_ds1_n;
            spindle_out_0_n <= nxt_mt0_n;
            spindle_out_1_n <= nxt_mt1_n;
            controller_reset <= sw_reset;
            dma_irq_gate    <= nxt_gate;
            low_power       <= lowp_ff;
            active_rate     <= rate_ff;
            write_shift_sel <= nxt_shift;
            tape_drive      <= tape_ff;
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    logic [1:0] type_id;
    logic [7:0] tape_rd;
    logic [7:0] rd_byte;

    // Pair chosen by the current drive code
    assign type_id = (pick == 2'h0) ? type_cfg[1:0] :
                     (pick == 2'h1) ? type_cfg[3:2] :
                     (pick == 2'h2) ? type_cfg[5:4] : type_cfg[7:6];

    // Normal mode shows only the tape bits
    assign tape_rd = enh2 ? {2'b00, type_id, boot_sel, tape_ff} : {6'h00, tape_ff};

    // Rate register is write-only and reads as zero here
    assign rd_byte = hit_dmc ? dmc_ff :
                     hit_tape ? tape_rd : 8'h00;

    // ----------------------------------------
    // APB answer
    // ----------------------------------------
    // No wait state: answer is staged in the setup cycle so every
    // bus output is a flop, and pready is high in the first access cycle.
    logic [31:0] nxt_prdata;
    logic        nxt_pready;
    logic        nxt_pslverr;

    assign nxt_pready  = setup_ph;
    assign nxt_prdata  = (setup_ph & ~pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
    assign nxt_pslverr = setup_ph & ~hit_any;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= nxt_prdata;
            pready  <= nxt_pready;
            pslverr <= nxt_pslverr;
        end
    end

endmodule

/* File: fdcr_top_checker.sv */
// Concurrent checks on the ports of the drive control register block
`timescale 1ns/1ps
module fdcr_top_checker (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        reset_n,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Configuration
    input wire logic        mode_extended,
    input wire logic        enhanced_mode2,
    input wire logic        drive_swap,
    // Drive and controller outputs
    input wire logic        unit_pick_0_n,
    input wire logic        unit_pick_1_n,
    input wire logic        spindle_out_0_n,
    input wire logic        spindle_out_1_n,
    input wire logic        controller_reset,
    input wire logic        dma_irq_gate
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // ----------------------------------------
    // Decodes
    // ----------------------------------------
    wire acc     = psel && penable && pready;
    wire wr_dmc  = acc && pwrite && paddr == 12'hfc8;
    wire wr_rate = acc && pwrite && paddr == 12'hfd0;
    wire rd      = acc && !pwrite;
    wire mapped  = paddr == 12'hfc8 || paddr == 12'hfcc || paddr == 12'hfd0;
    wire c0      = pwdata[1:0] == 2'h0 && pwdata[4];
    wire c1      = pwdata[1:0] == 2'h1 && pwdata[5];
    wire pick0   = drive_swap ? c1 : c0;
    wire pick1   = drive_swap ? c0 : c1;
    wire mot0    = drive_swap ? pwdata[5] : pwdata[4];
    wire mot1    = drive_swap ? pwdata[4] : pwdata[5];
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_one_pick; !(!unit_pick_0_n && !unit_pick_1_n); endproperty
    a_one_pick: assert property (p_one_pick) else $error("two drive selects active");
    property p_ready; psel && !penable |=> pready ##1 !pready; endproperty
    a_ready: assert property (p_ready) else $error("pready not one cycle after setup");
    property p_err; acc |-> pslverr == !mapped; endproperty
    a_err: assert property (p_err) else $error("pslverr wrong for address");
    property p_reset_in; wr_dmc && !pwdata[2] |=> ##[0:1] controller_reset; endproperty
    a_reset_in: assert property (p_reset_in) else $error("run bit clear gave no reset");
    property p_reset_min; $rose(controller_reset) |-> controller_reset [*2]; endproperty
    a_reset_min: assert property (p_reset_min) else $error("software reset shorter than 100ns");
    property p_rate_reset; wr_rate && pwdata[7] |=> ##[0:1] controller_reset; endproperty
    a_rate_reset: assert property (p_rate_reset) else $error("rate reset bit gave no reset");
    property p_motor;
        wr_dmc |-> ##2 spindle_out_0_n == !$past(mot0, 2) && spindle_out_1_n == !$past(mot1, 2);
    endproperty
    a_motor: assert property (p_motor) else $error("motor pins disagree with register");
    property p_pick;
        wr_dmc |-> ##2 unit_pick_0_n == !$past(pick0, 2) && unit_pick_1_n == !$past(pick1, 2);
    endproperty
    a_pick: assert property (p_pick) else $error("select pins disagree with register");
    property p_gate;
        wr_dmc |-> ##2 dma_irq_gate == ($past(mode_extended, 2) || $past(pwdata[3], 2));
    endproperty
    a_gate: assert property (p_gate) else $error("dma gate wrong for mode");
    property p_tape_rd; rd && paddr == 12'hfcc && !enhanced_mode2 |-> prdata[31:2] == 30'h0; endproperty
    a_tape_rd: assert property (p_tape_rd) else $error("tape upper bits not zero");
    property p_rate_rd; rd && paddr == 12'hfd0 |-> prdata == 32'h0; endproperty
    a_rate_rd: assert property (p_rate_rd) else $error("rate register readable");
    c_swap: cover property (wr_dmc && drive_swap);
    c_srst: cover property ($rose(controller_reset));
    c_err: cover property (acc && pslverr);
endmodule

/* File: fdcr_drive_pair.sv */
// Behavioural model of the two floppy drives on the select and motor pins
`timescale 1ns/1ps
module fdcr_drive_pair (
    // Drive pins
    input  wire logic       unit_pick_0_n,
    input  wire logic       unit_pick_1_n,
    input  wire logic       spindle_out_0_n,
    input  wire logic       spindle_out_1_n,
    // Observed drive state
    output logic      [1:0] spinning,
    output logic      [1:0] selected
);
    // ----------------------------------------
    // Pins seen by the drives
    // ----------------------------------------
    assign spinning = {!spindle_out_1_n, !spindle_out_0_n};
    // Select is not masked by motor, so a stray select stays visible
    assign selected = {!unit_pick_1_n, !unit_pick_0_n};
endmodule

/* File: tb_top.sv */
// Self-checking bench for the drive control register block
`timescale 1ns/1ps
module tb_top;
    logic        mclk, reset_n, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        mode_extended, enhanced_mode2, drive_swap, ccr_rate_wr, data_status_access;
    logic [7:0]  drive_type_config;
    logic [1:0]  boot_drive, ccr_rate, active_rate, tape_drive, spinning, selected;
    logic        unit_pick_0_n, unit_pick_1_n, spindle_out_0_n, spindle_out_1_n;
    logic        controller_reset, dma_irq_gate, low_power;
    logic [2:0]  write_shift_sel;
    int          num_errors, check_count, cycles, hi;
    // ----------------------------------------
    // Design and drives
    // ----------------------------------------
    fdcr_top uut (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mode_extended(mode_extended), .enhanced_mode2(enhanced_mode2), .drive_swap(drive_swap),
        .drive_type_config(drive_type_config), .boot_drive(boot_drive), .ccr_rate_wr(ccr_rate_wr),
        .ccr_rate(ccr_rate), .data_status_access(data_status_access), .unit_pick_0_n(unit_pick_0_n),
        .unit_pick_1_n(unit_pick_1_n), .spindle_out_0_n(spindle_out_0_n), .spindle_out_1_n(spindle_out_1_n),
        .controller_reset(controller_reset), .dma_irq_gate(dma_irq_gate), .low_power(low_power),
        .active_rate(active_rate), .write_shift_sel(write_shift_sel), .tape_drive(tape_drive));
    fdcr_drive_pair u_drv (.unit_pick_0_n(unit_pick_0_n), .unit_pick_1_n(unit_pick_1_n),
        .spindle_out_0_n(spindle_out_0_n), .spindle_out_1_n(spindle_out_1_n),
        .spinning(spinning), .selected(selected));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (controller_reset === 1'b1) hi++;
        if (cycles > 20000) begin
            num_errors++;
            conclude();
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic pins(input logic [7:0] d);
        logic [1:0] want;
        want = {d[1:0] == 2'h1 && d[5], d[1:0] == 2'h0 && d[4]};
        apb(1'b1, 12'hfc8, d);
        settle(2);
        chk("selected", drive_swap ? {want[0], want[1]} : want, selected);
        chk("spinning", drive_swap ? {d[4], d[5]} : {d[5], d[4]}, spinning);
        chk("dma_irq_gate", mode_extended | d[3], dma_irq_gate);
        apb(1'b0, 12'hfc8, 8'h00);
        chk("dmc readback", {24'h0, d}, rd);
    endtask
    task automatic conclude;
        $display("Errors %0d of %0d checks", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset_values;
        chk("active_rate", 2'h2, active_rate);
        chk("write_shift_sel", 3'h3, write_shift_sel);
        chk("controller_reset", 1'b1, controller_reset);
        chk("selected", 2'h0, selected);
        $display("reset values done");
    endtask
    task automatic t_decode;
        logic [7:0] tbl [5];
        tbl = '{8'h03, 8'h2d, 8'h5e, 8'h9f, 8'h14};
        foreach (tbl[i]) pins(tbl[i]);
        $display("decode done, swap %0d", drive_swap);
    endtask
    task automatic t_tape_rate;
        apb(1'b1, 12'hfcc, 8'hff);
        apb(1'b0, 12'hfcc, 8'h00);
        chk("tape read", 32'h3, rd);
        chk("tape_drive", 2'h3, tape_drive);
        apb(1'b0, 12'hfd0, 8'h00);
        chk("rate read", 32'h0, rd);
        apb(1'b1, 12'h000, 8'h55);
        chk("unmapped err", 1'b1, err);
        $display("tape and map done");
    endtask
    task automatic t_soft_reset;
        hi = 0;
        apb(1'b1, 12'hfc8, 8'h10);
        apb(1'b1, 12'hfc8, 8'h14);
        settle(6);
        chk("reset long enough", 1'b1, hi >= 2);
        chk("reset released", 1'b0, controller_reset);
        apb(1'b0, 12'hfc8, 8'h00);
        chk("dmc kept", 32'h14, rd);
        chk("tape kept", 2'h3, tape_drive);
        hi = 0;
        apb(1'b1, 12'hfd0, 8'h83);
        settle(6);
        chk("rate reset pulse", 1'b1, hi >= 2);
        chk("rate reset clears", 1'b0, controller_reset);
        chk("active_rate", 2'h3, active_rate);
        chk("write_shift_sel", 3'h1, write_shift_sel);
        $display("software reset done");
    endtask
    task automatic t_rate_power;
        @(posedge mclk);
        ccr_rate_wr <= 1'b1;
        ccr_rate <= 2'h1;
        @(posedge mclk);
        ccr_rate_wr <= 1'b0;
        settle(3);
        chk("active_rate ccr", 2'h1, active_rate);
        chk("default precomp", 3'h3, write_shift_sel);
        apb(1'b1, 12'hfd0, 8'h54);
        settle(3);
        chk("low_power", 1'b1, low_power);
        chk("precomp", 3'h5, write_shift_sel);
        chk("active_rate", 2'h0, active_rate);
        @(posedge mclk);
        data_status_access <= 1'b1;
        @(posedge mclk);
        data_status_access <= 1'b0;
        settle(3);
        chk("low_power exit", 1'b0, low_power);
        $display("rate and power done");
    endtask
    task automatic t_swapped;
        @(posedge mclk);
        reset_n <= 1'b0;
        drive_swap <= 1'b1;
        mode_extended <= 1'b1;
        enhanced_mode2 <= 1'b1;
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        settle(4);
        chk("active_rate hw", 2'h2, active_rate);
        chk("gate extended", 1'b1, dma_irq_gate);
        t_decode();
        apb(1'b1, 12'hfcc, 8'h01);
        pins(8'h26);
        apb(1'b0, 12'hfcc, 8'h00);
        chk("enhanced tape read", 32'h29, rd);
        $display("swapped extended done");
    endtask
    initial begin
        {psel, penable, pwrite, ccr_rate_wr, data_status_access} = '0;
        {mode_extended, enhanced_mode2, drive_swap} = '0;
        paddr = 12'h0;
        pwdata = 32'h0;
        ccr_rate = 2'h0;
        drive_type_config = 8'he4;
        boot_drive = 2'h2;
        reset_n = 1'b0;
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        settle(4);
        t_reset_values();
        t_decode();
        t_tape_rate();
        t_soft_reset();
        t_rate_power();
        t_swapped();
        conclude();
    end
endmodule
bind fdcr_top fdcr_top_checker u_chk (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mode_extended(mode_extended), .enhanced_mode2(enhanced_mode2), .drive_swap(drive_swap),
    .unit_pick_0_n(unit_pick_0_n), .unit_pick_1_n(unit_pick_1_n), .spindle_out_0_n(spindle_out_0_n),
    .spindle_out_1_n(spindle_out_1_n), .controller_reset(controller_reset), .dma_irq_gate(dma_irq_gate));
